// >>> core/tmr_pkg.sv
// Constants, types and register map of the capture/reload/baud timer.
package tmr_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MODE = 8'h04;
  localparam logic [7:0] ADDR_CNT_LO = 8'h08;
  localparam logic [7:0] ADDR_CNT_HI = 8'h0C;
  localparam logic [7:0] ADDR_CAP_LO = 8'h10;
  localparam logic [7:0] ADDR_CAP_HI = 8'h14;

  // Control register bit positions.
  localparam int CTRL_CRSEL = 0;
  localparam int CTRL_TCSEL = 1;
  localparam int CTRL_RUN = 2;
  localparam int CTRL_EXEN = 3;
  localparam int CTRL_TXB = 4;
  localparam int CTRL_RXB = 5;
  localparam int CTRL_EXF = 6;
  localparam int CTRL_OVF = 7;

  // Mode register bit positions.
  localparam int MODE_DOWN_COUNT_ENABLE = 0;
  localparam int MODE_CKOE = 1;
  localparam int MODE_X2 = 2;

  // Reset values.
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [2:0] MODE_RST = 3'h0;

  // Oscillator clocks per machine cycle, and its derived last prescaler state.
  localparam int MCYC_CLOCKS = 6;
  localparam logic [2:0] MCYC_LAST = 3'(MCYC_CLOCKS - 1);

  // Count limits and the overflow divider of the baud tick.
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] COUNT_MIN = 16'h0000;
  localparam logic [3:0] BAUD_DIV_LAST = 4'hF;

  // Operating modes, one-hot.
  typedef enum logic [4:0] {
    MD_OFF = 5'h01,
    MD_AUTO = 5'h02,
    MD_CAPT = 5'h04,
    MD_CLKOUT = 5'h08,
    MD_BAUD = 5'h10
  } tmr_mode_t;

  // Whole state of the timer block.
  typedef struct packed {
    logic [7:0] ctrl;
    logic [2:0] modr;
    logic [15:0] count;
    logic [15:0] cap;
    logic [2:0] presc;
    logic half;
    logic trig_s1;
    logic trig_s2;
    logic trig_prev;
    logic trig_fall;
    logic cnt_s1;
    logic cnt_s2;
    logic cnt_prev;
    logic clk_out;
    logic oe_n;
    logic [3:0] baud_div;
    logic tx_tick;
    logic rx_tick;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } tmr_state_t;

  // State after reset: pin released, everything else cleared.
  localparam tmr_state_t STATE_RST = '{oe_n: 1'b1, default: '0};

endpackage : tmr_pkg

// >>> core/tmr_timer16.sv
// 16-bit capture / auto-reload / clock-out / baud timer with APB registers.
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module tmr_timer16
  import tmr_pkg::*;
(
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic [31:0] PRDATA,
  input wire logic TRIG_PIN,
  input wire logic COUNT_PIN_IN,
  output logic COUNT_PIN_OUT,
  output logic COUNT_PIN_OE_N,
  input wire logic OTHER_BAUD_TICK,
  output logic TX_BAUD_TICK,
  output logic RX_BAUD_TICK,
  output logic TIMER_IRQ
);

  // The register bus is a plain APB slave with one fixed wait-free answer.
  // Every register is eight bits wide or less and sits in the low byte of
  // its word, so software can use byte or word accesses with the same result.
  // Unmapped offsets answer with an error and never change any state, which
  // keeps a stray write from a runaway program away from the counter.
  // The decode is a function used only by the error answer; the read path keeps
  // its own copy in read_mux, and the two copies could drift apart when the map grows.
  // Address decode for the error answer; the read path decodes in read_mux.
  function automatic logic addr_mapped(input logic [7:0] a);
    begin
      addr_mapped = (a == ADDR_CTRL) || (a == ADDR_MODE) ||
                    (a == ADDR_CNT_LO) || (a == ADDR_CNT_HI) ||
                    (a == ADDR_CAP_LO) || (a == ADDR_CAP_HI);
    end
  endfunction : addr_mapped

  // The operating mode is decoded once per cycle from the stored setup bits.
  // Baud use is checked right after the run bit because it overrides the capture select and
  // must also keep the pin from being driven if clock-out is requested too.
  // Clock-out needs the internal time base, so an external count select
  // quietly falls back to the capture or auto-reload modes instead.
  // A stopped timer decodes as off, which freezes the count and all events.
  // Mode decode from the control and mode registers.
  function automatic tmr_mode_t mode_of(input logic [7:0] c, input logic [2:0] m);
    begin
      if (!c[CTRL_RUN])
      begin
        mode_of = MD_OFF;
      end
      else if (c[CTRL_TXB] || c[CTRL_RXB])
      begin
        mode_of = MD_BAUD;
      end
      else if (m[MODE_CKOE] && !c[CTRL_TCSEL])
      begin
        mode_of = MD_CLKOUT;
      end
      else if (c[CTRL_CRSEL])
      begin
        mode_of = MD_CAPT;
      end
      else
      begin
        mode_of = MD_AUTO;
      end
    end
  endfunction : mode_of

  // The read data is taken from the registered state in the setup cycle.
  // Count bytes are not latched as a pair, so a running count read high byte
  // first and low byte second may tear; software should stop the timer first.
  // Register read multiplexer; unused upper bits read as zero.
  function automatic logic [31:0] read_mux(input logic [7:0] a, input tmr_state_t st);
    begin
      read_mux = 32'h0000_0000;
      case (a)
        ADDR_CTRL: read_mux[7:0] = st.ctrl;
        ADDR_MODE: read_mux[2:0] = st.modr;
        ADDR_CNT_LO: read_mux[7:0] = st.count[7:0];
        ADDR_CNT_HI: read_mux[7:0] = st.count[15:8];
        ADDR_CAP_LO: read_mux[7:0] = st.cap[7:0];
        ADDR_CAP_HI: read_mux[7:0] = st.cap[15:8];
        default: read_mux = 32'h0000_0000;
      endcase
    end
  endfunction : read_mux

  tmr_state_t s;
  tmr_state_t next_s;

  tmr_mode_t md;
  logic mtick;
  logic trig_act;
  logic cnt_edge;
  logic rate_en;
  logic step;
  logic down;
  logic wrap;
  logic own_tick;
  logic wr;
  logic setup;

  // All state lives in one packed struct so that the clock enable and the
  // reset act on every bit in the same way, with no stray flip-flop left out.
  // Helper signals below are pure decodes of this cycle and hold no state.
  // Priority inside the cycle: pin sampling, counting, bus writes, then the
  // hardware flag events, so that a hardware set always beats a software clear.
  // Next-state logic: everything holds while the clock enable is low.
  always_comb
  begin
    next_s = s;
    md = mode_of(s.ctrl, s.modr);
    mtick = 1'b0;
    trig_act = 1'b0;
    cnt_edge = 1'b0;
    rate_en = 1'b0;
    step = 1'b0;
    down = 1'b0;
    wrap = 1'b0;
    own_tick = 1'b0;
    wr = 1'b0;
    setup = 1'b0;
    if (CE)
    begin
      // Pins come from outside: two flip-flops before any logic reads them.
      next_s.trig_s1 = TRIG_PIN;
      next_s.trig_s2 = s.trig_s1;
      next_s.cnt_s1 = COUNT_PIN_IN;
      next_s.cnt_s2 = s.cnt_s1;

      mtick = (s.presc == MCYC_LAST);
      next_s.presc = mtick ? 3'h0 : s.presc + 3'h1;
      next_s.half = ~s.half;

      if (mtick)
      begin
        next_s.trig_prev = s.trig_s2;
        next_s.trig_fall = s.trig_prev & ~s.trig_s2;
        next_s.cnt_prev = s.cnt_s2;
      end
      trig_act = mtick & s.trig_fall;

      cnt_edge = mtick & s.cnt_prev & ~s.cnt_s2;

      // Count rate: on the internal time base, baud and clock-out run faster than the machine cycle.
      if (s.ctrl[CTRL_TCSEL])
      begin
        rate_en = cnt_edge;
      end
      else if (md == MD_BAUD)
      begin
        // oscillator rate, halved unless double speed
        rate_en = s.modr[MODE_X2] | s.half;
      end
      else if (md == MD_CLKOUT)
      begin
        // oscillator rate with toggle per wrap
        rate_en = 1'b1;
      end
      else
      begin
        rate_en = mtick;
      end
      step = rate_en && (md != MD_OFF);

      down = (md == MD_AUTO) && s.modr[MODE_DOWN_COUNT_ENABLE] && !s.trig_s2;

      // Up counting wraps at the top value; down counting stops at the reload
      // value and restarts from the top, so both directions share one period.
      // A reload value of the top itself gives a wrap on every step, which is
      // the fastest tick that the baud and clock-out paths can produce.
      // Counter stepping with overflow and underflow.
      if (step)
      begin
        if (down)
        begin
          if (s.count == s.cap)
          begin
            next_s.count = COUNT_MAX;
            wrap = 1'b1;
          end
          else
          begin
            next_s.count = s.count - 16'h0001;
          end
        end
        else if (s.count == COUNT_MAX)
        begin
          wrap = 1'b1;
          next_s.count = (md == MD_CAPT) ? COUNT_MIN : s.cap;
        end
        else
        begin
          next_s.count = s.count + 16'h0001;
        end
      end

      // The answer is registered, so the bus output timing never depends on
      // the address decode path; the cost is that ready rises one cycle after
      // setup even for the simplest register.
      // APB: ready follows the setup cycle, so every access has no wait state.
      setup = PSEL && !PENABLE;
      next_s.pready = setup;
      next_s.pslverr = setup && !addr_mapped(PADDR);
      if (setup)
      begin
        next_s.prdata = read_mux(PADDR, s);
      end
      wr = PSEL && PENABLE && s.pready && PWRITE;

      // Software writes win over a same-cycle counter step.
      if (wr)
      begin
        case (PADDR)
          ADDR_CTRL: next_s.ctrl = PWDATA[7:0];
          ADDR_MODE: next_s.modr = PWDATA[2:0];
          ADDR_CNT_LO: next_s.count[7:0] = PWDATA[7:0];
          ADDR_CNT_HI: next_s.count[15:8] = PWDATA[7:0];
          ADDR_CAP_LO: next_s.cap[7:0] = PWDATA[7:0];
          ADDR_CAP_HI: next_s.cap[15:8] = PWDATA[7:0];
          default: next_s.ctrl = next_s.ctrl;
        endcase
      end

      // Overflow flag: hardware set wins over a software clear.
      if (wrap && (md == MD_CAPT || md == MD_AUTO))
      begin
        // no flag in clock-out or baud
        next_s.ctrl[CTRL_OVF] = 1'b1;
      end

      if (wrap && md == MD_AUTO && s.modr[MODE_DOWN_COUNT_ENABLE])
      begin
        next_s.ctrl[CTRL_EXF] = ~next_s.ctrl[CTRL_EXF];
      end

      // Trigger edge events, only when the edge input is enabled.
      if (trig_act && s.ctrl[CTRL_EXEN])
      begin
        case (md)
          MD_CAPT:
          begin
            next_s.cap = s.count;
            next_s.ctrl[CTRL_EXF] = 1'b1;
          end
          MD_AUTO:
          begin
            if (!s.modr[MODE_DOWN_COUNT_ENABLE])
            begin
              next_s.count = s.cap;
              next_s.ctrl[CTRL_EXF] = 1'b1;
            end
          end
          MD_BAUD:
          begin
            next_s.ctrl[CTRL_EXF] = 1'b1;
          end
          default:
          begin
            next_s.ctrl[CTRL_EXF] = next_s.ctrl[CTRL_EXF];
          end
        endcase
      end

      // drive the count pin only in clock-out mode
      next_s.oe_n = (md != MD_CLKOUT);
      if (md == MD_CLKOUT && wrap)
      begin
        next_s.clk_out = ~s.clk_out;
      end

      if (md == MD_BAUD && wrap)
      begin
        next_s.baud_div = s.baud_div + 4'h1;
        own_tick = (s.baud_div == BAUD_DIV_LAST);
      end

      next_s.tx_tick = s.ctrl[CTRL_TXB] ? own_tick : OTHER_BAUD_TICK;
      next_s.rx_tick = s.ctrl[CTRL_RXB] ? own_tick : OTHER_BAUD_TICK;

      next_s.irq = next_s.ctrl[CTRL_OVF] | next_s.ctrl[CTRL_EXF];
    end
  end

  // Reset wins over the clock enable so that a frozen block still starts clean.
  // The reset value releases the shared pin, so nothing fights an outside
  // driver on the count pin until software asks for clock-out.
  // State register; synchronous reset loads constants only.
  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      s <= STATE_RST;
    end
    else
    begin
      s <= next_s;
    end
  end

  // Outputs are registered copies, which adds one cycle of latency to the
  // ticks (the interrupt is built from the next flags, so it adds none there) but keeps glitches off the pins and the bus.
  // Every output comes straight from a state flip-flop.
  assign PREADY = s.pready;
  assign PSLVERR = s.pslverr;
  assign PRDATA = s.prdata;
  assign COUNT_PIN_OUT = s.clk_out;
  assign COUNT_PIN_OE_N = s.oe_n;
  assign TX_BAUD_TICK = s.tx_tick;
  assign RX_BAUD_TICK = s.rx_tick;
  assign TIMER_IRQ = s.irq;

endmodule : tmr_timer16

`default_nettype wire

// >>> verification/tmr_timer16_assertions.sv
// Port checker for the capture/reload/baud timer.
`timescale 1ns/1ps
`default_nettype none
module tmr_checker
  import tmr_pkg::*;
(
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [31:0] PRDATA,
  input wire logic TRIG_PIN,
  input wire logic COUNT_PIN_IN,
  input wire logic COUNT_PIN_OUT,
  input wire logic COUNT_PIN_OE_N,
  input wire logic OTHER_BAUD_TICK,
  input wire logic TX_BAUD_TICK,
  input wire logic RX_BAUD_TICK,
  input wire logic TIMER_IRQ
);
  logic [5:0] cf;
  logic [2:0] md;
  logic [8:0] cfg;
  logic baud;
  logic clko;
  // Shadow of the software-owned setup bits; flags are left out as hardware moves them.
  always_ff @(posedge MCLK)
  begin
    if (SYS_RST)
    begin
      cf <= 6'h00;
      md <= 3'h0;
    end
    else if (PSEL && PENABLE && PWRITE && PREADY && !PSLVERR)
    begin
      if (PADDR == ADDR_CTRL)
        cf <= PWDATA[5:0];
      if (PADDR == ADDR_MODE)
        md <= PWDATA[2:0];
    end
  end
  // Baud use wins over clock-out, so the pin is driven only without it.
  assign cfg = {md, cf};
  assign baud = cf[2] && (cf[4] || cf[5]);
  assign clko = cf[2] && !cf[1] && md[1] && !baud;
  default clocking @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  AST_TX_OTHER: assert property (!cf[4] && !$past(cf[4])
    |-> TX_BAUD_TICK == $past(OTHER_BAUD_TICK)) else $error("tx tick source");
  AST_RX_OTHER: assert property (!cf[5] && !$past(cf[5])
    |-> RX_BAUD_TICK == $past(OTHER_BAUD_TICK)) else $error("rx tick source");
  AST_OE_CLKOUT: assert property (cfg == $past(cfg) && cfg == $past(cfg, 2)
    |-> COUNT_PIN_OE_N == !clko) else $error("pin enable wrong");
  AST_CLKOUT_QUIET: assert property (clko && $past(clko)
    |-> !$rose(TIMER_IRQ)) else $error("irq in clock-out");
  AST_BAUD_QUIET: assert property (baud && !cf[3] && $past(baud)
    |-> !$rose(TIMER_IRQ)) else $error("irq in baud mode");
  AST_IRQ_HOLD: assert property ($fell(TIMER_IRQ)
    |-> $past(PSEL) && $past(PWRITE)) else $error("irq fell alone");
  AST_TX_SPACE: assert property (TX_BAUD_TICK && cf[4] && baud
    |=> !TX_BAUD_TICK [*8]) else $error("tx ticks too close");
  AST_RX_SPACE: assert property (RX_BAUD_TICK && cf[5] && baud
    |=> !RX_BAUD_TICK [*8]) else $error("rx ticks too close");
  cover property (!COUNT_PIN_OE_N);
  cover property (TX_BAUD_TICK && cf[4]);
  cover property ($rose(TIMER_IRQ));
endmodule : tmr_checker
bind tmr_timer16 tmr_checker i_tmr_checker (.MCLK(MCLK), .SYS_RST(SYS_RST), .CE(CE),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .PRDATA(PRDATA), .TRIG_PIN(TRIG_PIN),
  .COUNT_PIN_IN(COUNT_PIN_IN), .COUNT_PIN_OUT(COUNT_PIN_OUT), .COUNT_PIN_OE_N(COUNT_PIN_OE_N),
  .OTHER_BAUD_TICK(OTHER_BAUD_TICK), .TX_BAUD_TICK(TX_BAUD_TICK),
  .RX_BAUD_TICK(RX_BAUD_TICK), .TIMER_IRQ(TIMER_IRQ));
`default_nettype wire

// >>> verification/tmr_pin_model.sv
// Far side of the timer: shared count pin, trigger pin and the other timer's tick.
`timescale 1ns/1ps
`default_nettype none
module tmr_pin_model
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic trig_lvl,
  input wire logic cnt_lvl,
  input wire logic pin_out,
  input wire logic oe_n,
  output logic trig_pin,
  output logic cnt_pin,
  output var logic other_tick
);
  logic [3:0] div;
  // shared pin
  // The block owns the pin while its enable is low; otherwise the outside level shows.
  assign cnt_pin = oe_n ? cnt_lvl : pin_out;
  assign trig_pin = trig_lvl;
  // The other timer ticks every ten clocks, so its pulses never look like ours.
  always_ff @(posedge mclk)
  begin
    div <= (sys_rst || div == 4'h9) ? 4'h0 : div + 4'h1;
    other_tick <= !sys_rst && div == 4'h9;
  end
endmodule : tmr_pin_model
`default_nettype wire

// >>> verification/test_timer16_capture_reload_baud.sv
// Register-level bench of the capture/reload/baud timer.
`timescale 1ns/1ps
`default_nettype none
module test_timer16_capture_reload_baud
  import tmr_pkg::*;
;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, serr, pin_out, oe_n, irq, tx, rx, trig_pin, cnt_pin, other;
  logic trig = 1'b1;
  logic cnt = 1'b1;
  int n_mismatch = 0;
  int tests_run = 0;
  int n;
  // Clock at 40 MHz.
  always #12.5 mclk = ~mclk;
  tmr_timer16 i_tmr_timer16 (.MCLK(mclk), .SYS_RST(sys_rst), .CE(1'b1), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready),
    .PSLVERR(pslverr), .PRDATA(prdata), .TRIG_PIN(trig_pin), .COUNT_PIN_IN(cnt_pin),
    .COUNT_PIN_OUT(pin_out), .COUNT_PIN_OE_N(oe_n), .OTHER_BAUD_TICK(other),
    .TX_BAUD_TICK(tx), .RX_BAUD_TICK(rx), .TIMER_IRQ(irq));
  tmr_pin_model i_tmr_pin_model (.mclk(mclk), .sys_rst(sys_rst), .trig_lvl(trig),
    .cnt_lvl(cnt), .pin_out(pin_out), .oe_n(oe_n), .trig_pin(trig_pin),
    .cnt_pin(cnt_pin), .other_tick(other));
  task chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task finish_test;
    $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test
  // A wait that used up its bound ends the run as a failure.
  task bound(input int k, input int lim);
    if (k >= lim)
    begin
      n_mismatch++;
      finish_test();
    end
  endtask : bound
  // One APB transfer; the request stands until pready is seen high at an edge.
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge mclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
    bound(k, 20);
  endtask : xfer
  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask : rd
  // Count pin falls; each level is held two machine cycles, well under osc/12.
  task pulses(input int c);
    repeat (c)
    begin
      cnt <= 1'b0;
      repeat (12) @(posedge mclk);
      cnt <= 1'b1;
      repeat (12) @(posedge mclk);
    end
    repeat (30) @(posedge mclk);
  endtask : pulses
  task fall;
    trig <= 1'b0;
    repeat (30) @(posedge mclk);
    trig <= 1'b1;
    repeat (30) @(posedge mclk);
  endtask : fall
  // Clocks between two events: a tx tick, or a change of the clock-out pin.
  task gap(input logic s);
    logic p;
    repeat (2)
    begin
      p = pin_out;
      n = 0;
      do
      begin
        @(posedge mclk);
        #1;
        n++;
      end
      while (!(s ? tx === 1'b1 : pin_out !== p) && n < 500);
      if (s)
        chk(rx, 1'b1);
    end
    @(posedge mclk);
    bound(n, 500);
  endtask : gap
  // Main sequence: reset, then each mode in turn.
  initial
  begin
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(ADDR_MODE, 0);
    rd(8'h18, 0);
    chk(serr, 1);
    wr(ADDR_CNT_LO, 'h34);
    wr(ADDR_CNT_HI, 'h12);
    wr(ADDR_CTRL, 'h0F);
    fall();
    rd(ADDR_CAP_LO, 'h34);
    rd(ADDR_CAP_HI, 'h12);
    rd(ADDR_CTRL, 'h4F);
    chk(irq, 1);
    wr(ADDR_CNT_HI, 'hAB);
    fall();
    rd(ADDR_CAP_HI, 'hAB);
    pulses(2);
    rd(ADDR_CNT_LO, 'h36);
    wr(ADDR_CTRL, 'h07);
    rd(ADDR_CTRL, 'h07);
    chk(irq, 0);
    wr(ADDR_CNT_LO, 'hFF);
    wr(ADDR_CNT_HI, 'hFF);
    pulses(1);
    rd(ADDR_CNT_HI, 0);
    rd(ADDR_CTRL, 'h87);
    wr(ADDR_CTRL, 'h06);
    wr(ADDR_CAP_HI, 'h10);
    wr(ADDR_CAP_LO, 0);
    wr(ADDR_CNT_LO, 'hFF);
    wr(ADDR_CNT_HI, 'hFF);
    pulses(1);
    rd(ADDR_CNT_HI, 'h10);
    rd(ADDR_CTRL, 'h86);
    wr(ADDR_CTRL, 'h0E);
    wr(ADDR_CNT_HI, 'h22);
    fall();
    rd(ADDR_CNT_HI, 'h10);
    rd(ADDR_CTRL, 'h4E);
    wr(ADDR_CTRL, 'h06);
    wr(ADDR_MODE, 1);
    trig <= 1'b0;
    pulses(1);
    rd(ADDR_CNT_HI, 'hFF);
    rd(ADDR_CTRL, 'hC6);
    trig <= 1'b1;
    pulses(1);
    rd(ADDR_CNT_HI, 'h10);
    rd(ADDR_CTRL, 'h86);
    wr(ADDR_CAP_LO, 'hF0);
    wr(ADDR_CAP_HI, 'hFF);
    wr(ADDR_CNT_LO, 'hF0);
    wr(ADDR_CNT_HI, 'hFF);
    wr(ADDR_MODE, 2);
    wr(ADDR_CTRL, 'h04);
    gap(1'b0);
    chk(n, 16);
    chk(oe_n, 0);
    wr(ADDR_CAP_LO, 'hFF);
    wr(ADDR_MODE, 0);
    wr(ADDR_CTRL, 'h34);
    gap(1'b1);
    chk(n, 32);
    wr(ADDR_MODE, 4);
    gap(1'b1);
    chk(n, 16);
    wr(ADDR_CTRL, 'h3C);
    fall();
    rd(ADDR_CTRL, 'h7C);
    finish_test();
  end
endmodule : test_timer16_capture_reload_baud
`default_nettype wire
